// ==== hdl/ebus_pkg.sv ====
// package for the external bus strobe control block: register map,
// field positions, reset values, state codes and carrier structs.
// assumes a 125 MHz CLOCK that stands for the oscillator.
package ebus_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_CONFIG   = 8'h00; // configuration_register
  localparam logic [7:0] OFF_CONFIG1  = 8'h04; // config_register_1
  localparam logic [7:0] OFF_PIN_FUNC = 8'h08; // bus function per pin
  localparam logic [7:0] OFF_LOW_SPEED_IO_OUT = 8'h0c; // low_speed_io levels
  localparam logic [7:0] OFF_PORT_OUT = 8'h10; // ports 3 and 4 latch
  localparam logic [7:0] OFF_STATUS   = 8'h14; // block state, read only
  localparam logic [7:0] OFF_PORT_IN  = 8'h18; // ports 3 and 4 pins

  // configuration_register fields
  localparam int CFG_WR_LOW    = 0; // 1: store_low_byte_strobe
  localparam int CFG_WIDTH16   = 1; // 16-bit bus select
  localparam int CFG_HI_STROBE = 2; // 1: store_high_byte_strobe
  localparam int CFG_ADV       = 3; // 1: address_valid_strobe
  localparam int CFG_WAIT_LO   = 4; // wait limit bits 1:0 at 5:4
  // config_register_1 fields
  localparam int CFG1_WAIT_HI  = 0; // wait limit bit 2
  localparam int CFG1_DYNAMIC  = 2; // dynamic width enable

  // pin function enables, 1 selects the bus function
  localparam int PF_RD    = 0;
  localparam int PF_WR    = 1;
  localparam int PF_HI    = 2;
  localparam int PF_READY = 3;
  localparam int PF_ASTB  = 4;
  localparam int PF_CLK   = 5;
  localparam int PF_WIDTH = 6;
  localparam int PF_BITS  = 7;

  // reset values: 16-bit fixed width, all bus functions, limit 7
  localparam logic [5:0] CONFIG_RST   = 6'h32;
  localparam logic [2:0] CONFIG1_RST  = 3'h1;
  localparam logic [6:0] PIN_FUNC_RST = 7'h7f;
  localparam logic [4:0] LOW_SPEED_IO_RST     = 5'h1f;
  localparam logic [15:0] PORT_RST    = 16'hffff;

  localparam int WAIT_W = 3; // width of the wait limit

  // bus cycle states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_STRB = 4'b0100,
    ST_WAIT = 4'b1000
  } bus_state_t;

  // access request from the cpu core
  typedef struct packed {
    logic        valid;
    logic        ext;    // goes to external memory
    logic        write;
    logic [1:0]  lanes;  // bit0 low byte, bit1 high byte
    logic [15:0] addr;
    logic [15:0] wdata;
  } core_req_t;

  // control pins toward memory
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic hi_n;
    logic astb;
    logic clock_out_pin;
  } bus_pins_t;

endpackage

// ==== hdl/ebus_wait_limit.sv ====
// wait state counter with a programmable ceiling.
// assumes count_en pulses once per clock_out_pin period.
`timescale 1ns/10ps
module ebus_wait_limit
#(
  parameter int W = 3
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         count_en,
  input  wire logic [W-1:0] limit,
  output logic              reached,
  output logic [W-1:0]      count
);

  // counts inserted wait states, cleared at each bus cycle start
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (count_en && !reached)
      count <= count + W'(1);
  end

  // a zero limit means the stretch ends at the first wait check
  assign reached = (count >= limit);

endmodule

// ==== hdl/ebus_strobe_ctrl.sv ====
// external bus strobe and wait state control with apb registers.
// assumes core requests hold until CORE_ACK and CLOCK is the oscillator.
//
// Summary of operation
// - read strobe low only during external read cycles.
// - config bit picks write or low-byte write strobe; external writes only.
// - write strobe mode: pin low on every external write.
// - low-byte write mode: pin low only when the even byte is written.
// - 16-bit lanes: low 0/1, high 1/0, both 0/0 as bit zero/enable.
// - high-byte write strobe mode: pin low when writing an odd location.
// - high-byte pin valid only during 16-bit external read and write cycles.
// - ready high lets a bus cycle finish without wait states.
// - ready low before clock falling edge waits until a rising edge with ready.
// - ready is ignored for accesses that are not external.
// - wait states per cycle capped by limit held in both config registers.
// - control pins without bus function act as plain port pins.
// - ports 3/4 open drain as ports, driven strongly as the bus.
// - address strobe pin is latch enable or valid strobe by config.
// - valid strobe returns high at the end of each access, not between the two cycles of a split.
// - dynamic width: width pin low gives 8-bit cycle, high 16-bit.
// - clock out is half the oscillator with 50% duty.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
module ebus_strobe_ctrl
(
  input  wire logic               CLOCK,
  input  wire logic               NRST,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic [31:0]             PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // core side
  input  wire ebus_pkg::core_req_t CORE_REQ,
  output logic                    CORE_ACK,
  output logic [15:0]             CORE_RDATA,
  // external pins
  input  wire logic               READY,
  input  wire logic               BUS_WIDTH_SELECT,
  output ebus_pkg::bus_pins_t     PINS,
  input  wire logic [15:0]        AD_IN,
  output logic [15:0]             AD_OUT,
  output logic [15:0]             AD_OE_N
);

  logic [5:0]                      config_reg;
  logic [2:0]                      config1_reg;
  logic [ebus_pkg::PF_BITS-1:0]    pin_func;
  logic [4:0]                      low_speed_io_out;
  logic [15:0]                     port_out;
  ebus_pkg::bus_state_t            state;
  logic                            phase;     // 1: clock_out_pin low half
  logic                            ready_low; // ready seen low this period
  logic                            cyc_wide;  // current cycle is 16-bit
  logic                            split;     // second byte still to do
  logic                            busy_ext;
  logic [15:0]                     cur_addr;
  logic [1:0]                      cur_lanes;
  logic                            wait_clear;
  logic                            wait_step;
  logic                            wait_reached;
  logic [ebus_pkg::WAIT_W-1:0]     wait_count;
  logic [ebus_pkg::WAIT_W-1:0]     wait_limit;
  logic                            ready_eff;
  logic                            cycle_end;
  logic                            apb_wr;
  logic                            internal_ack;
  ebus_pkg::bus_pins_t             next_pins;
  logic [15:0]                     next_ad_out;
  logic [15:0]                     next_ad_oe_n;

  // decides the width of a cycle from the two config bits and the pin
  function automatic logic width_is_16(input logic [5:0] cfg,
                                       input logic [2:0] cfg1,
                                       input logic       pin);
    logic w16;
    logic dyn;
    w16 = cfg[ebus_pkg::CFG_WIDTH16];
    dyn = cfg1[ebus_pkg::CFG1_DYNAMIC];
    // both bits zero is illegal; it falls back to 8-bit cycles
    width_is_16 = (w16 && dyn) ? pin : (w16 && !dyn);
  endfunction

  // address bit zero follows the lanes: only a high-byte-only access is odd
  function automatic logic lane_a0(input logic [1:0] lanes);
    lane_a0 = (lanes == 2'b10);
  endfunction

  assign wait_limit = {config1_reg[ebus_pkg::CFG1_WAIT_HI],
                       config_reg[ebus_pkg::CFG_WAIT_LO +: 2]};
  // a pin not in ready function cannot stretch anything
  assign ready_eff  = READY || !pin_func[ebus_pkg::PF_READY];
  assign busy_ext   = (state != ebus_pkg::ST_IDLE);

  // clock_out_pin: toggles every oscillator clock, so half rate, 50% duty
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      phase <= 1'b0;
    else
      phase <= !phase;
  end

  // apb: zero wait states, unmapped offsets refused with pslverr
  assign PREADY = 1'b1;
  assign apb_wr = PSEL && PENABLE && PWRITE;

  always_comb
  begin
    PSLVERR = 1'b0;
    PRDATA  = 32'h0000_0000;
    unique case (PADDR)
      ebus_pkg::OFF_CONFIG:   PRDATA = {26'h0, config_reg};
      ebus_pkg::OFF_CONFIG1:  PRDATA = {29'h0, config1_reg};
      ebus_pkg::OFF_PIN_FUNC: PRDATA = {25'h0, pin_func};
      ebus_pkg::OFF_LOW_SPEED_IO_OUT: PRDATA = {27'h0, low_speed_io_out};
      ebus_pkg::OFF_PORT_OUT: PRDATA = {16'h0, port_out};
      ebus_pkg::OFF_STATUS:
        PRDATA = {23'h0, wait_count, cyc_wide, BUS_WIDTH_SELECT, READY,
                  (state == ebus_pkg::ST_WAIT), busy_ext, 1'b0};
      ebus_pkg::OFF_PORT_IN:  PRDATA = {16'h0, AD_IN};
      default:                PSLVERR = PSEL && PENABLE;
    endcase
  end

  // software registers; written at the access-phase edge only
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      config_reg  <= ebus_pkg::CONFIG_RST;
      config1_reg <= ebus_pkg::CONFIG1_RST;
      pin_func    <= ebus_pkg::PIN_FUNC_RST;
      low_speed_io_out    <= ebus_pkg::LOW_SPEED_IO_RST;
      port_out    <= ebus_pkg::PORT_RST;
    end
    else if (apb_wr)
    begin
      if (PADDR == ebus_pkg::OFF_CONFIG)
        config_reg <= PWDATA[5:0];
      if (PADDR == ebus_pkg::OFF_CONFIG1)
        config1_reg <= PWDATA[2:0];
      if (PADDR == ebus_pkg::OFF_PIN_FUNC)
        pin_func <= PWDATA[ebus_pkg::PF_BITS-1:0];
      if (PADDR == ebus_pkg::OFF_LOW_SPEED_IO_OUT)
        low_speed_io_out <= PWDATA[4:0];
      if (PADDR == ebus_pkg::OFF_PORT_OUT)
        port_out <= PWDATA[15:0];
    end
  end

  // ready is checked in the high half, before clock_out_pin falls
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      ready_low <= 1'b0;
    else if (!phase && state == ebus_pkg::ST_STRB)
      ready_low <= !ready_eff;
    else if (state != ebus_pkg::ST_STRB)
      ready_low <= 1'b0;
  end

  // a cycle ends at a period boundary once ready is high or the cap hits
  always_comb
  begin
    cycle_end = 1'b0;
    if (phase)
    begin
      if (state == ebus_pkg::ST_STRB)
        cycle_end = !ready_low;
      else if (state == ebus_pkg::ST_WAIT)
        cycle_end = ready_eff || wait_reached;
    end
  end

  assign wait_clear = (state == ebus_pkg::ST_ADDR);
  // counted as each wait period opens, so a limit of n from 1 up gives n waits; a limit of 0 gives one
  assign wait_step  = !phase && (state == ebus_pkg::ST_WAIT);

  ebus_wait_limit #(.W(ebus_pkg::WAIT_W)) u_wait
  (
    .clk      (CLOCK),
    .nrst     (NRST),
    .clear    (wait_clear),
    .count_en (wait_step),
    .limit    (wait_limit),
    .reached  (wait_reached),
    .count    (wait_count)
  );

  // internal accesses never touch the pins and never see ready
  assign internal_ack = CORE_REQ.valid && !CORE_REQ.ext && !busy_ext
                        && !CORE_ACK;

  // bus cycle sequencer; new cycles start only at a period boundary
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      state     <= ebus_pkg::ST_IDLE;
      cyc_wide  <= 1'b0;
      split     <= 1'b0;
      cur_addr  <= 16'h0000;
      cur_lanes <= 2'b00;
    end
    else
    begin
      unique case (state)
        ebus_pkg::ST_IDLE:
          if (phase && CORE_REQ.valid && CORE_REQ.ext && !CORE_ACK)
          begin
            state    <= ebus_pkg::ST_ADDR;
            cyc_wide <= width_is_16(config_reg, config1_reg,
                          BUS_WIDTH_SELECT || !pin_func[ebus_pkg::PF_WIDTH]);
            cur_addr <= CORE_REQ.addr;
            cur_lanes <= CORE_REQ.lanes;
            split    <= 1'b0;
          end
        ebus_pkg::ST_ADDR:
        begin
          // an 8-bit bus moves a two-byte access as two cycles
          if (phase && !cyc_wide && cur_lanes == 2'b11)
          begin
            cur_lanes <= 2'b01;
            split     <= 1'b1;
          end
          if (phase)
            state <= ebus_pkg::ST_STRB;
        end
        ebus_pkg::ST_STRB, ebus_pkg::ST_WAIT:
          if (cycle_end)
          begin
            if (split)
            begin
              state     <= ebus_pkg::ST_ADDR;
              cur_addr  <= cur_addr | 16'h0001;
              cur_lanes <= 2'b10;
              split     <= 1'b0;
            end
            else
              state <= ebus_pkg::ST_IDLE;
          end
          else if (phase && ready_low)
            state <= ebus_pkg::ST_WAIT;
      endcase
    end
  end

  // read data capture and the one-cycle acknowledge to the core
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      CORE_ACK   <= 1'b0;
      CORE_RDATA <= 16'h0000;
    end
    else
    begin
      CORE_ACK <= internal_ack || (cycle_end && !split);
      if (cycle_end && !CORE_REQ.write)
      begin
        // an odd 8-bit byte arrives on the low lane
        if (!cyc_wide && cur_lanes == 2'b10)
          CORE_RDATA[15:8] <= AD_IN[7:0];
        else if (!cyc_wide)
          CORE_RDATA[7:0] <= AD_IN[7:0];
        else
          CORE_RDATA <= AD_IN;
      end
    end
  end

  // pin values for the next clock; registered below
  always_comb
  begin
    logic strobing;
    logic rd_fn;
    logic wr_fn;
    logic hi_fn;
    logic as_fn;
    strobing = (state == ebus_pkg::ST_STRB) || (state == ebus_pkg::ST_WAIT);
    // read and write are mutually exclusive by the request direction
    rd_fn = !(strobing && !CORE_REQ.write);
    wr_fn = !(strobing && CORE_REQ.write);
    if (config_reg[ebus_pkg::CFG_WR_LOW])
      wr_fn = !(strobing && CORE_REQ.write && cur_lanes[0]);
    // only meaningful in 16-bit cycles; idles high otherwise
    hi_fn = !(busy_ext && cyc_wide && cur_lanes[1]);
    if (config_reg[ebus_pkg::CFG_HI_STROBE])
      hi_fn = !(strobing && CORE_REQ.write && cur_lanes[1]);
    as_fn = (state == ebus_pkg::ST_ADDR) && !phase;
    if (config_reg[ebus_pkg::CFG_ADV])
      as_fn = !busy_ext;
    // pins with the bus function off show their port latch
    next_pins.rd_n   = pin_func[ebus_pkg::PF_RD]   ? rd_fn : low_speed_io_out[0];
    next_pins.wr_n   = pin_func[ebus_pkg::PF_WR]   ? wr_fn : low_speed_io_out[1];
    next_pins.hi_n   = pin_func[ebus_pkg::PF_HI]   ? hi_fn : low_speed_io_out[2];
    next_pins.astb   = pin_func[ebus_pkg::PF_ASTB] ? as_fn : low_speed_io_out[3];
    next_pins.clock_out_pin = pin_func[ebus_pkg::PF_CLK]  ? phase : low_speed_io_out[4];
    // applied in the five selections above
  end

  // address/data drive: strong as the bus, open drain as ports
  always_comb
  begin
    next_ad_out  = 16'h0000;
    next_ad_oe_n = 16'hffff;
    if (state == ebus_pkg::ST_ADDR)
    begin
      next_ad_out    = {cur_addr[15:1], lane_a0(cur_lanes)};
      next_ad_oe_n   = 16'h0000;
    end
    else if (busy_ext && CORE_REQ.write)
    begin
      if (!cyc_wide && cur_lanes == 2'b10)
        next_ad_out = {8'h00, CORE_REQ.wdata[15:8]};
      else
        next_ad_out = CORE_REQ.wdata;
      next_ad_oe_n  = 16'h0000;
    end
    else if (!busy_ext)
    begin
      // port bits only pull low; a one is left to the pull-up
      next_ad_out  = 16'h0000;
      next_ad_oe_n = port_out;
    end
  end

  // pin registers so that every pin output comes from a flip-flop
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      PINS    <= '{rd_n: 1'b1, wr_n: 1'b1, hi_n: 1'b1, astb: 1'b0,
                   clock_out_pin: 1'b0};
      AD_OUT  <= 16'h0000;
      AD_OE_N <= 16'hffff;
    end
    else
    begin
      PINS    <= next_pins;
      AD_OUT  <= next_ad_out;
      AD_OE_N <= next_ad_oe_n;
    end
  end

endmodule

// ==== tb/ebus_checker.sv ====
// concurrent checks on the strobe control pins and core handshake.
// assumes it is bound to the strobe control top and sees its ports.
`timescale 1ns/10ps
module ebus_checker
(
  input wire logic                CLOCK,
  input wire logic                NRST,
  input wire ebus_pkg::core_req_t CORE_REQ,
  input wire logic                CORE_ACK,
  input wire logic                READY,
  input wire ebus_pkg::bus_pins_t PINS,
  input wire logic [15:0]         AD_OE_N
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  logic [4:0] low_cnt;

  // read strobe length, saturating so a stuck strobe still fails
  always_ff @(posedge CLOCK or negedge NRST)
    if (!NRST)
      low_cnt <= 5'h00;
    else if (PINS.rd_n)
      low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f)
      low_cnt <= low_cnt + 5'h01;

  strobe_excl_a: assert property (PINS.rd_n || PINS.wr_n)
    else $error("read and write strobes low together");
  rd_release_a: assert property (!PINS.rd_n |-> AD_OE_N == 16'hffff)
    else $error("bus driven while read strobe low");
  wr_drive_a: assert property (!PINS.wr_n |-> AD_OE_N[7:0] == 8'h00)
    else $error("write data not driven during write strobe");
  clk_half_a: assert property ($past(NRST, 2) |->
    PINS.clock_out_pin != $past(PINS.clock_out_pin))
    else $error("clock out missed a toggle");
  int_quiet_a: assert property (CORE_ACK && !CORE_REQ.ext |->
    PINS.rd_n && PINS.wr_n)
    else $error("strobe active around an internal access");
  rd_plain_a: assert property ($fell(PINS.rd_n) && READY |=>
    !PINS.rd_n ##1 PINS.rd_n)
    else $error("read strobe length wrong with ready high");
  rd_wait_a: assert property ($fell(PINS.rd_n) && !READY |=>
    !PINS.rd_n [*3])
    else $error("no wait state with ready low");
  wait_cap_a: assert property (low_cnt <= 5'h10)
    else $error("wait states beyond the largest limit");
endmodule

bind ebus_strobe_ctrl ebus_checker ebus_checker_inst
(
  .CLOCK   (CLOCK),
  .NRST    (NRST),
  .CORE_REQ(CORE_REQ),
  .CORE_ACK(CORE_ACK),
  .READY   (READY),
  .PINS    (PINS),
  .AD_OE_N (AD_OE_N)
);

// ==== tb/ebus_mem.sv ====
// external memory model: 16 words, latches the address off the bus,
// answers reads, takes writes, and stretches strobes by holding ready low.
`timescale 1ns/10ps
module ebus_mem
(
  input  wire logic                CLOCK,
  input  wire ebus_pkg::bus_pins_t PINS,
  input  wire logic [15:0]         AD_OUT,
  input  wire logic [15:0]         AD_OE_N,
  input  wire logic                LANE_MODE,
  input  wire logic                W8,
  input  wire logic                ADDRESS_VALID_STROBE,
  input  wire logic                PARK,
  input  wire logic [7:0]          STALL,
  output logic                     READY,
  output logic [15:0]              AD_IN
);
  logic [15:0] mem [16];
  logic [15:0] a = 16'h0000;
  logic [15:0] rdv;
  logic [7:0]  n = 8'h00;
  logic        act;
  logic        act_q = 1'b0;
  logic        held = 1'b0;
  logic        strb;

  // released lines float to the pull-up; memory drives only on read
  assign rdv = W8 ? {8'hff, a[0] ? mem[a[4:1]][15:8] : mem[a[4:1]][7:0]}
                  : mem[a[4:1]];
  assign AD_IN = (AD_OE_N & (PINS.rd_n ? 16'hffff : rdv)) |
                 (~AD_OE_N & AD_OUT);
  assign act = ADDRESS_VALID_STROBE ? !PINS.astb : PINS.astb;
  assign strb = !(PINS.rd_n && PINS.wr_n);
  // ready pulled low from the address latch on, as address decode
  // must do to be seen before the strobe's first period ends
  assign READY = !PARK && !(n != 8'h00 && n <= STALL);

  // address latched at the start of the strobe pulse, either form
  always @(posedge CLOCK)
  begin
    act_q <= act;
    held <= strb;
    if (act && !act_q && AD_OE_N == 16'h0000)
    begin
      a <= AD_IN;
      n <= 8'h01;
    end
    else if (held && !strb)
      n <= 8'h00;
    else if (n != 8'h00 && n != 8'hff)
      n <= n + 8'h01;
    if (LANE_MODE ? !PINS.wr_n : !PINS.wr_n && !a[0])
      mem[a[4:1]][7:0] <= AD_IN[7:0];
    if (LANE_MODE ? !PINS.hi_n : !PINS.wr_n && !PINS.hi_n)
      mem[a[4:1]][15:8] <= AD_IN[15:8];
  end
endmodule

// ==== tb/ebus_strobe_ctrl_tb.sv ====
// top bench: apb master, core request driver, memory model and checks.
// assumes the strobe control block, its bound checker and the model.
`timescale 1ns/10ps
module ebus_strobe_ctrl_tb;
  logic                clock = 1'b0;
  logic                nrst = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  ebus_pkg::core_req_t creq = '0;
  logic                ack;
  logic [15:0]         rdata;
  logic                ready;
  logic                bws = 1'b1;
  ebus_pkg::bus_pins_t pins;
  logic [15:0]         ad_in;
  logic [15:0]         ad_out;
  logic [15:0]         ad_oe_n;
  logic                lmode = 1'b0;
  logic                park = 1'b0;
  logic                address_valid_strobe = 1'b0;
  logic [7:0]          stall = 8'h00;
  int                  n_errors = 0;
  int                  checks_done = 0;
  int                  len;
  int                  falls;
  int                  n;
  logic                rd_q = 1'b1;
  logic                wr_seen;
  logic                hi_seen;
  logic                adv_seen;
  logic [31:0]         r;
  logic [31:0]         got;
  logic                e;

  ebus_strobe_ctrl ebus_strobe_ctrl_inst (.CLOCK(clock), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CORE_REQ(creq), .CORE_ACK(ack), .CORE_RDATA(rdata), .READY(ready),
    .BUS_WIDTH_SELECT(bws), .PINS(pins), .AD_IN(ad_in), .AD_OUT(ad_out),
    .AD_OE_N(ad_oe_n));
  ebus_mem ebus_mem_inst (.CLOCK(clock), .PINS(pins), .AD_OUT(ad_out),
    .AD_OE_N(ad_oe_n), .LANE_MODE(lmode), .W8(!bws), .ADDRESS_VALID_STROBE(address_valid_strobe),
    .PARK(park), .STALL(stall), .READY(ready), .AD_IN(ad_in));

  // 8 ns clock
  initial
    forever #4 clock = ~clock;

  // strobe monitor: read strobe cycles and falls, other strobes seen
  always @(posedge clock)
  begin
    if (pins.rd_n === 1'b0)
      len++;
    if (pins.rd_n === 1'b0 && rd_q)
      falls++;
    rd_q = pins.rd_n;
    wr_seen |= (pins.wr_n === 1'b0);
    hi_seen |= (pins.hi_n === 1'b0);
    adv_seen |= (pins.astb === 1'b0 && pins.rd_n === 1'b0);
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic clr;
    len = 0;
    falls = 0;
    wr_seen = 1'b0;
    hi_seen = 1'b0;
    adv_seen = 1'b0;
  endtask

  // one apb transfer, request held until pready is sampled high;
  // one idle edge after it so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // core request held until the ack edge; n counts edges waited
  task automatic core(input logic x, input logic w, input logic [1:0] ln,
                      input logic [15:0] a, input logic [15:0] d);
    n = 1;
    creq <= '{1'b1, x, w, ln, a, d};
    @(posedge clock);
    while (ack !== 1'b1)
    begin
      @(posedge clock);
      n++;
    end
    got = {16'h0000, rdata};
    creq.valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic t_regs;
    logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] vals [5] = '{32'h32, 32'h1, 32'h7f, 32'h1f, 32'hffff};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, offs[i], 32'h0);
      chk(r, vals[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_wide;
    core(1'b1, 1'b1, 2'b11, 16'h0004, 16'ha55a);
    core(1'b1, 1'b0, 2'b11, 16'h0004, 16'h0000);
    chk(got, 32'ha55a);
    core(1'b1, 1'b1, 2'b01, 16'h0006, 16'h1234);
    core(1'b1, 1'b1, 2'b10, 16'h0007, 16'hab00);
    core(1'b1, 1'b0, 2'b11, 16'h0006, 16'h0000);
    chk(got, 32'hab34);
    $display("test wide done");
  endtask

  task automatic t_lanes;
    apb(1'b1, 8'h00, 32'h37);
    lmode <= 1'b1;
    clr();
    core(1'b1, 1'b1, 2'b10, 16'h0009, 16'h5500);
    chk({30'h0, wr_seen, hi_seen}, 32'h1);
    clr();
    core(1'b1, 1'b1, 2'b01, 16'h0008, 16'h0066);
    chk({30'h0, wr_seen, hi_seen}, 32'h2);
    apb(1'b1, 8'h00, 32'h32);
    lmode <= 1'b0;
    core(1'b1, 1'b0, 2'b11, 16'h0008, 16'h0000);
    chk(got, 32'h5566);
    $display("test lanes done");
  endtask

  // long stall: strobe stops at the limit split over both registers
  task automatic t_wait;
    logic [31:0] cf [3] = '{32'h32, 32'h12, 32'h22};
    logic [31:0] c1 [3] = '{32'h1, 32'h0, 32'h0};
    logic [31:0] ex [3] = '{32'h10, 32'h4, 32'h6};
    stall <= 8'hc8;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 8'h00, cf[i]);
      apb(1'b1, 8'h04, c1[i]);
      clr();
      core(1'b1, 1'b0, 2'b11, 16'h0004, 16'h0000);
      chk(32'(len), ex[i]);
    end
    stall <= 8'h00;
    apb(1'b1, 8'h00, 32'h32);
    apb(1'b1, 8'h04, 32'h1);
    $display("test wait done");
  endtask

  task automatic t_int;
    park <= 1'b1;
    clr();
    core(1'b0, 1'b0, 2'b11, 16'h0100, 16'h0000);
    chk(32'(n), 32'h2);
    chk(32'(len), 32'h0);
    park <= 1'b0;
    $display("test internal done");
  endtask

  task automatic t_low_speed_io;
    apb(1'b1, 8'h08, 32'h7b);
    apb(1'b1, 8'h0c, 32'h1b);
    repeat (3) @(posedge clock);
    chk({31'h0, pins.hi_n}, 32'h0);
    apb(1'b1, 8'h0c, 32'h1f);
    repeat (3) @(posedge clock);
    chk({31'h0, pins.hi_n}, 32'h1);
    apb(1'b1, 8'h08, 32'h7f);
    $display("test low_speed_io done");
  endtask

  task automatic t_adv;
    apb(1'b1, 8'h00, 32'h3a);
    address_valid_strobe <= 1'b1;
    clr();
    core(1'b1, 1'b0, 2'b11, 16'h0004, 16'h0000);
    chk(got, 32'ha55a);
    chk({30'h0, adv_seen, pins.astb}, 32'h3);
    apb(1'b1, 8'h00, 32'h32);
    address_valid_strobe <= 1'b0;
    $display("test adv done");
  endtask

  // dynamic width: a two-byte read splits in two 8-bit cycles
  task automatic t_w8;
    apb(1'b1, 8'h04, 32'h5);
    bws <= 1'b0;
    clr();
    core(1'b1, 1'b0, 2'b11, 16'h0004, 16'h0000);
    chk(got, 32'ha55a);
    chk(32'(falls), 32'h2);
    bws <= 1'b1;
    clr();
    core(1'b1, 1'b0, 2'b11, 16'h0004, 16'h0000);
    chk(32'(falls), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h38);
    apb(1'b1, 8'h04, 32'h1);
    $display("test width done");
  endtask

  // main sequence after a four cycle reset
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_wide();
    t_lanes();
    t_wait();
    t_int();
    t_low_speed_io();
    t_adv();
    t_w8();
    results();
  end

  // watchdog, well past the expected length of the run
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    results();
  end
endmodule
